// >>> rtl/regbank_pkg.sv
package regbank_pkg;
	localparam int XLEN = 32;
	localparam int NUM_GPR = 31;
	localparam int NUM_STATUS = 6;
	localparam int NUM_VISIBLE = 16;
	localparam logic [3:0] IDX_PC = 4'hf;
	localparam logic [3:0] IDX_LINK = 4'he;
	localparam logic [3:0] IDX_SP = 4'hd;
	localparam logic [3:0] IDX_FAST_LO = 4'h8;
	localparam logic [3:0] IDX_SHARED_HI = 4'h7;
	// Mode field encodings
	localparam logic [4:0] MODE_USER = 5'h10;
	localparam logic [4:0] MODE_FAST = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1b;
	localparam logic [4:0] MODE_SYS = 5'h1f;
	// Vector table, base at zero
	localparam logic [31:0] VEC_BASE = 32'h0000_0000;
	localparam logic [31:0] VEC_UND = 32'h0000_0004;
	localparam logic [31:0] VEC_TRAP = 32'h0000_0008;
	localparam logic [31:0] VEC_ABT = 32'h0000_0010;
	localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
	localparam logic [31:0] VEC_FAST = 32'h0000_001c;
	localparam logic [31:0] PC_RESET = 32'h0000_0000;
	localparam logic [31:0] PC_AHEAD = 32'h0000_0008;
	// Exception request bit positions
	localparam int EXC_ABT = 0;
	localparam int EXC_FAST = 1;
	localparam int EXC_IRQ = 2;
	localparam int EXC_UND = 3;
	localparam int EXC_TRAP = 4;
	localparam int NUM_EXC = 5;
	// Bank slots: 0 user/system, 1..5 exception modes
	localparam int BANK_USR = 0;
	localparam int BANK_FAST = 1;
	localparam int BANK_IRQ = 2;
	localparam int BANK_SVC = 3;
	localparam int BANK_ABT = 4;
	localparam int BANK_UND = 5;
	localparam int NUM_BANK = 6;

	typedef struct packed {
		logic neg;
		logic zero;
		logic carry;
		logic ovf;
		logic [19:0] rsvd;
		logic irq_off;
		logic fast_off;
		logic narrow;
		logic [4:0] mode;
	} status_word_t;

	localparam status_word_t STATUS_RESET = '{neg: 1'b0, zero: 1'b0, carry: 1'b0, ovf: 1'b0,
		rsvd: 20'h0_0000, irq_off: 1'b1, fast_off: 1'b1, narrow: 1'b0, mode: MODE_SVC};

	typedef struct packed {
		logic we;
		logic [3:0] idx;
		logic [31:0] data;
	} reg_write_t;

	typedef struct packed {
		logic valid;
		logic [3:0] cond;
		logic is_call;
		logic ret_dp;
		logic ret_ldm;
		logic [31:0] next_pc;
	} instr_ctl_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_ENTER = 2'b10
	} exc_state_t;
endpackage

// >>> rtl/banked_register_file_exception_state.sv
`timescale 1ns/1ns
// How it works
// - 31 general plus 6 status registers
// - Sixteen registers visible, chosen by mode
// - Index fifteen reads as program counter
// - Call writes return address to link
// - Indices 0-7 shared by all modes
// - Indices 13-14 banked by mode
// - Each exception mode owns SP, link
// - Entry writes return address to link
// - Fast mode also banks 8-12
// - System mode uses user registers, privileged
// - Vector table based at address zero
// - Status word: flags, disables, width, mode
// - Saved status gets prior status word
// - Five exception classes, own modes
// - Entry touches only target bank copies
// - Return restores status and PC
// - Execute only when condition holds
// - Simultaneous requests kept pending
module banked_register_file_exception_state
	import regbank_pkg::*;
#(
	parameter int DATA_W = XLEN
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] rd_idx_a_i,
	input wire logic [3:0] rd_idx_b_i,
	input wire instr_ctl_t instr_i,
	input wire reg_write_t wr_i,
	input wire logic [3:0] flags_i,
	input wire logic flags_we_i,
	input wire logic status_we_i,
	input wire logic [NUM_EXC-1:0] exc_req_i,
	input wire logic [31:0] exc_ret_addr_i,
	output logic [31:0] rd_data_a_o,
	output logic [31:0] rd_data_b_o,
	output logic [31:0] pc_o,
	output status_word_t status_o,
	output logic cond_pass_o,
	output logic exc_taken_o,
	output logic [4:0] exc_mode_o,
	output logic [NUM_EXC-1:0] exc_pending_o
);
	if (DATA_W != XLEN) begin : g_width_check
		$error("DATA_W must equal 32");
	end

	// ==========================================================
	// Storage
	// physical register arrays
	logic [31:0] shared_ff [0:7];
	logic [31:0] hi_usr_ff [0:4];
	logic [31:0] hi_fast_ff [0:4];
	logic [31:0] sp_ff [0:NUM_BANK-1];
	logic [31:0] link_ff [0:NUM_BANK-1];
	logic [31:0] pc_ff;
	status_word_t current_status_word_ff;
	status_word_t saved_status_word_ff [1:NUM_BANK-1];
	logic [NUM_EXC-1:0] pend_ff;
	exc_state_t state_ff;

	function automatic int bank_of(input logic [4:0] m);
		unique case (m)
			MODE_FAST: bank_of = BANK_FAST;
			MODE_IRQ: bank_of = BANK_IRQ;
			MODE_SVC: bank_of = BANK_SVC;
			MODE_ABT: bank_of = BANK_ABT;
			MODE_UND: bank_of = BANK_UND;
			default: bank_of = BANK_USR;
		endcase
	endfunction

	function automatic logic cond_ok(input logic [3:0] c, input status_word_t s);
		unique case (c)
			4'h0: cond_ok = s.zero;
			4'h1: cond_ok = !s.zero;
			4'h2: cond_ok = s.carry;
			4'h3: cond_ok = !s.carry;
			4'h4: cond_ok = s.neg;
			4'h5: cond_ok = !s.neg;
			4'h6: cond_ok = s.ovf;
			4'h7: cond_ok = !s.ovf;
			4'h8: cond_ok = s.carry && !s.zero;
			4'h9: cond_ok = !s.carry || s.zero;
			4'ha: cond_ok = s.neg == s.ovf;
			4'hb: cond_ok = s.neg != s.ovf;
			4'hc: cond_ok = !s.zero && (s.neg == s.ovf);
			4'hd: cond_ok = s.zero || (s.neg != s.ovf);
			4'he: cond_ok = 1'b1;
			default: cond_ok = 1'b0;
		endcase
	endfunction

	int cur_bank;
	logic fast_bank;
	logic exec;
	logic ret_now;
	logic [4:0] tgt_mode;
	logic [31:0] tgt_vec;
	int tgt_bank;
	logic [NUM_EXC-1:0] pend_all;
	logic [NUM_EXC-1:0] grant;
	logic take;
	logic [NUM_EXC-1:0] mask_off;
	logic [NUM_EXC-1:0] clr;
	logic [NUM_EXC-1:0] nxt_pend;
	status_word_t wr_ctl;

	assign cur_bank = bank_of(current_status_word_ff.mode);
	assign fast_bank = current_status_word_ff.mode == MODE_FAST;
	assign exec = instr_i.valid && cond_ok(instr_i.cond, current_status_word_ff);
	// return trigger, only from an exception mode
	assign ret_now = exec && (instr_i.ret_dp || instr_i.ret_ldm) && cur_bank != BANK_USR;
	// Masked interrupts stay pending until enabled
	assign mask_off = {3'h0, current_status_word_ff.irq_off, current_status_word_ff.fast_off} << EXC_FAST;
	assign pend_all = (pend_ff | exc_req_i) & ~mask_off;

	always_comb begin
		grant = '0;
		tgt_mode = MODE_SVC;
		tgt_vec = VEC_TRAP;
		tgt_bank = BANK_SVC;
		if (pend_all[EXC_ABT]) begin
			grant[EXC_ABT] = 1'b1;
			tgt_mode = MODE_ABT;
			tgt_vec = VEC_ABT;
			tgt_bank = BANK_ABT;
		end else if (pend_all[EXC_FAST]) begin
			grant[EXC_FAST] = 1'b1;
			tgt_mode = MODE_FAST;
			tgt_vec = VEC_FAST;
			tgt_bank = BANK_FAST;
		end else if (pend_all[EXC_IRQ]) begin
			grant[EXC_IRQ] = 1'b1;
			tgt_mode = MODE_IRQ;
			tgt_vec = VEC_IRQ;
			tgt_bank = BANK_IRQ;
		end else if (pend_all[EXC_UND]) begin
			grant[EXC_UND] = 1'b1;
			tgt_mode = MODE_UND;
			tgt_vec = VEC_UND;
			tgt_bank = BANK_UND;
		end else if (pend_all[EXC_TRAP]) begin
			grant[EXC_TRAP] = 1'b1;
		end
	end
	assign take = |grant && state_ff == ST_RUN && !ret_now;
	assign clr = take ? grant : '0;
	// A request granted on arrival is consumed, else a second entry would follow
	assign nxt_pend = (pend_ff & ~clr) | (exc_req_i & (pend_ff | ~clr));
	assign wr_ctl = wr_i.data;

	// ==========================================================
	// Visible register read
	function automatic logic [31:0] rd_view(input logic [3:0] i, input int b, input logic f,
		input logic [31:0] pc);
		if (i == IDX_PC) begin
			// PC read ahead of current instruction
			rd_view = pc + PC_AHEAD;
		end else if (i <= IDX_SHARED_HI) begin
			rd_view = shared_ff[i[2:0]];
		end else if (i == IDX_SP) begin
			rd_view = sp_ff[b];
		end else if (i == IDX_LINK) begin
			rd_view = link_ff[b];
		end else begin
			rd_view = f ? hi_fast_ff[3'(i - IDX_FAST_LO)] : hi_usr_ff[3'(i - IDX_FAST_LO)];
		end
	endfunction

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_a_o <= 32'h0000_0000;
			rd_data_b_o <= 32'h0000_0000;
		end else begin
			rd_data_a_o <= rd_view(rd_idx_a_i, cur_bank, fast_bank, pc_ff);
			rd_data_b_o <= rd_view(rd_idx_b_i, cur_bank, fast_bank, pc_ff);
		end
	end

	// ==========================================================
	// General register writes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int k = 0; k < 8; k++) shared_ff[k] <= 32'h0000_0000;
			for (int k = 0; k < 5; k++) begin
				hi_usr_ff[k] <= 32'h0000_0000;
				hi_fast_ff[k] <= 32'h0000_0000;
			end
			for (int k = 0; k < NUM_BANK; k++) begin
				sp_ff[k] <= 32'h0000_0000;
				link_ff[k] <= 32'h0000_0000;
			end
		end else if (take) begin
			link_ff[tgt_bank] <= exc_ret_addr_i;
		end else if (exec) begin
			if (instr_i.is_call) begin
				link_ff[cur_bank] <= instr_i.next_pc;
			end
			if (wr_i.we && wr_i.idx != IDX_PC) begin
				if (wr_i.idx <= IDX_SHARED_HI) shared_ff[wr_i.idx[2:0]] <= wr_i.data;
				else if (wr_i.idx == IDX_SP) sp_ff[cur_bank] <= wr_i.data;
				else if (wr_i.idx == IDX_LINK) link_ff[cur_bank] <= wr_i.data;
				else if (fast_bank) hi_fast_ff[3'(wr_i.idx - IDX_FAST_LO)] <= wr_i.data;
				else hi_usr_ff[3'(wr_i.idx - IDX_FAST_LO)] <= wr_i.data;
			end
		end
	end

	// ==========================================================
	// Program counter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_ff <= PC_RESET;
		end else if (take) begin
			pc_ff <= VEC_BASE + tgt_vec;
		end else if (ret_now) begin
			pc_ff <= link_ff[cur_bank];
		end else if (exec && wr_i.we && wr_i.idx == IDX_PC) begin
			pc_ff <= wr_i.data;
		end else if (instr_i.valid) begin
			pc_ff <= instr_i.next_pc;
		end
	end

	// ==========================================================
	// Status words
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			current_status_word_ff <= STATUS_RESET;
			for (int k = 1; k < NUM_BANK; k++) saved_status_word_ff[k] <= STATUS_RESET;
		end else if (take) begin
			saved_status_word_ff[tgt_bank] <= current_status_word_ff;
			current_status_word_ff.mode <= tgt_mode;
			current_status_word_ff.narrow <= 1'b0;
			current_status_word_ff.irq_off <= 1'b1;
			if (tgt_mode == MODE_FAST) current_status_word_ff.fast_off <= 1'b1;
		end else if (ret_now) begin
			current_status_word_ff <= saved_status_word_ff[cur_bank];
		end else if (exec) begin
			// Privileged status transfer; only way to unmask interrupts besides exception return
			if (status_we_i && current_status_word_ff.mode != MODE_USER) begin
				current_status_word_ff.irq_off <= wr_ctl.irq_off;
				current_status_word_ff.fast_off <= wr_ctl.fast_off;
				current_status_word_ff.narrow <= wr_ctl.narrow;
				current_status_word_ff.mode <= wr_ctl.mode;
			end
			if (flags_we_i) begin
				{current_status_word_ff.neg, current_status_word_ff.zero,
					current_status_word_ff.carry, current_status_word_ff.ovf} <= flags_i;
			end
		end
	end

	// ==========================================================
	// Pending requests and entry sequencing
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_ff <= '0;
		end else begin
			pend_ff <= nxt_pend;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= ST_RUN;
		end else begin
			unique case (state_ff)
				ST_RUN: state_ff <= take ? ST_ENTER : ST_RUN;
				ST_ENTER: state_ff <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			exc_taken_o <= 1'b0;
			exc_mode_o <= MODE_SVC;
			exc_pending_o <= '0;
			cond_pass_o <= 1'b0;
		end else begin
			exc_taken_o <= take;
			exc_mode_o <= take ? tgt_mode : exc_mode_o;
			exc_pending_o <= nxt_pend;
			cond_pass_o <= exec;
		end
	end

	assign pc_o = pc_ff;
	assign status_o = current_status_word_ff;

	// ==========================================================
	// Checks
	property p_entry_vector;
		@(posedge clk_i) disable iff (!rst_n_i) take && grant[EXC_ABT] |=> pc_ff == VEC_ABT;
	endproperty
	a_entry_vector: assert property (p_entry_vector) else $error("abort vector wrong");
	property p_saved;
		@(posedge clk_i) disable iff (!rst_n_i)
			take && grant[EXC_IRQ] |=> saved_status_word_ff[BANK_IRQ] == $past(current_status_word_ff);
	endproperty
	a_saved: assert property (p_saved) else $error("saved status wrong");
	property p_link;
		@(posedge clk_i) disable iff (!rst_n_i)
			take && grant[EXC_UND] |=> link_ff[BANK_UND] == $past(exc_ret_addr_i);
	endproperty
	a_link: assert property (p_link) else $error("entry link wrong");
	property p_user_link_kept;
		@(posedge clk_i) disable iff (!rst_n_i) take |=> $stable(link_ff[BANK_USR]);
	endproperty
	a_user_link_kept: assert property (p_user_link_kept) else $error("user link touched");
	property p_prio;
		@(posedge clk_i) disable iff (!rst_n_i) take && pend_all[EXC_ABT] |=> current_status_word_ff.mode == MODE_ABT;
	endproperty
	a_prio: assert property (p_prio) else $error("abort not first");
	property p_pending_kept;
		@(posedge clk_i) disable iff (!rst_n_i) exc_req_i[EXC_TRAP] && take && !grant[EXC_TRAP] |=> pend_ff[EXC_TRAP];
	endproperty
	a_pending_kept: assert property (p_pending_kept) else $error("request lost");
	property p_return;
		@(posedge clk_i) disable iff (!rst_n_i) ret_now |=> pc_ff == $past(link_ff[cur_bank]);
	endproperty
	a_return: assert property (p_return) else $error("return PC wrong");
	property p_cond_never;
		@(posedge clk_i) disable iff (!rst_n_i) instr_i.valid && instr_i.cond == 4'hf |=> !cond_pass_o;
	endproperty
	a_cond_never: assert property (p_cond_never) else $error("never-condition executed");
	property p_pc_read;
		@(posedge clk_i) disable iff (!rst_n_i) rd_idx_a_i == IDX_PC |=> rd_data_a_o == $past(pc_ff) + PC_AHEAD;
	endproperty
	a_pc_read: assert property (p_pc_read) else $error("PC read wrong");
	c_fast: cover property (@(posedge clk_i) disable iff (!rst_n_i) take && grant[EXC_FAST]);
	c_two: cover property (@(posedge clk_i) disable iff (!rst_n_i) $countones(exc_req_i) > 1);
	c_ret: cover property (@(posedge clk_i) disable iff (!rst_n_i) ret_now);
endmodule

// >>> sim/banked_register_file_exception_state_tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin fails++; \
	$display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module banked_register_file_exception_state_tb_top
	import regbank_pkg::*;
;
	localparam logic [3:0] C_EQ = 4'h0;
	localparam logic [3:0] C_NE = 4'h1;
	localparam logic [3:0] C_AL = 4'he;
	localparam logic [3:0] C_NV = 4'hf;
	logic clk_i;
	logic rst_n_i;
	logic [3:0] rd_idx_a_i;
	logic [3:0] rd_idx_b_i;
	instr_ctl_t instr_i;
	reg_write_t wr_i;
	logic [3:0] flags_i;
	logic flags_we_i;
	logic status_we_i;
	logic [NUM_EXC-1:0] exc_req_i;
	logic [31:0] exc_ret_addr_i;
	logic [31:0] rd_data_a_o;
	logic [31:0] rd_data_b_o;
	logic [31:0] pc_o;
	status_word_t status_o;
	logic cond_pass_o;
	logic exc_taken_o;
	logic [4:0] exc_mode_o;
	logic [NUM_EXC-1:0] exc_pending_o;
	int fails = 0;
	int n_checks = 0;

	banked_register_file_exception_state dut_u (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_idx_a_i(rd_idx_a_i), .rd_idx_b_i(rd_idx_b_i),
		.instr_i(instr_i), .wr_i(wr_i), .flags_i(flags_i), .flags_we_i(flags_we_i),
		.status_we_i(status_we_i),
		.exc_req_i(exc_req_i), .exc_ret_addr_i(exc_ret_addr_i), .rd_data_a_o(rd_data_a_o),
		.rd_data_b_o(rd_data_b_o), .pc_o(pc_o), .status_o(status_o), .cond_pass_o(cond_pass_o),
		.exc_taken_o(exc_taken_o), .exc_mode_o(exc_mode_o), .exc_pending_o(exc_pending_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ==========================================
	// Bus helpers
	function automatic reg_write_t w_of(input logic [3:0] idx, input logic [31:0] d);
		return '{we: 1'b1, idx: idx, data: d};
	endfunction

	task automatic end_of_test();
		if (fails == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		#1;
	endtask

	// One instruction; k = {call, ret_dp, ret_ldm}, f = {flags_we, flags}
	task automatic exec(input logic [3:0] c, input reg_write_t w, input logic [2:0] k, input logic [4:0] f,
		input logic [31:0] npc);
		@(posedge clk_i);
		instr_i <= '{valid: 1'b1, cond: c, is_call: k[2], ret_dp: k[1], ret_ldm: k[0], next_pc: npc};
		wr_i <= w;
		{flags_we_i, flags_i} <= f;
		@(posedge clk_i);
		instr_i <= '0;
		wr_i <= '0;
		flags_we_i <= 1'b0;
		#1;
	endtask

	task automatic chk_reg(input logic [3:0] idx, input logic [31:0] exp);
		@(posedge clk_i);
		rd_idx_a_i <= idx;
		rd_idx_b_i <= idx;
		@(posedge clk_i);
		#1;
		`CHK("rd_data_a_o", exp, rd_data_a_o)
		`CHK("rd_data_b_o", exp, rd_data_b_o)
	endtask

	task automatic exc(input logic [NUM_EXC-1:0] r, input logic [31:0] a);
		@(posedge clk_i);
		exc_req_i <= r;
		exc_ret_addr_i <= a;
		@(posedge clk_i);
		exc_req_i <= '0;
		#1;
	endtask

	// Entry pulse lasts one cycle, so look before stepping
	task automatic wait_taken();
		for (int i = 0; i < 8; i++) begin
			if (exc_taken_o === 1'b1) begin
				return;
			end
			@(posedge clk_i);
			#1;
		end
		fails++;
		$display("MISMATCH exc_taken_o expected 1 seen timeout");
		end_of_test();
	endtask

	// ==========================================
	// Scenarios
	// Status transfer: control bits come from the write data
	task automatic set_ctl(input status_word_t s);
		@(posedge clk_i);
		instr_i <= '{valid: 1'b1, cond: C_AL, is_call: 1'b0, ret_dp: 1'b0, ret_ldm: 1'b0, next_pc: 32'h0};
		wr_i <= '{we: 1'b0, idx: 4'h0, data: s};
		status_we_i <= 1'b1;
		@(posedge clk_i);
		instr_i <= '0;
		wr_i <= '0;
		status_we_i <= 1'b0;
		#1;
	endtask

	task automatic t_reset();
		`CHK("status_o", STATUS_RESET, status_o)
		`CHK("pc_o", PC_RESET, pc_o)
		`CHK("exc_mode_o", MODE_SVC, exc_mode_o)
		`CHK("exc_pending_o", 5'h00, exc_pending_o)
		chk_reg(IDX_PC, PC_RESET + PC_AHEAD);
	endtask

	task automatic t_banking();
		exec(C_AL, w_of(4'h0, 32'h1111_0000), 3'h0, 5'h00, 32'h0);
		exec(C_AL, w_of(4'h8, 32'h8888_0000), 3'h0, 5'h00, 32'h0);
		exec(C_AL, w_of(IDX_SP, 32'hdddd_0000), 3'h0, 5'h00, 32'h0);
		exec(C_AL, w_of(IDX_LINK, 32'heeee_0000), 3'h0, 5'h00, 32'h0);
		exc(5'h01, 32'h0000_0100);
		wait_taken();
		`CHK("pc_o", VEC_ABT, pc_o)
		`CHK("mode", MODE_ABT, status_o.mode)
		`CHK("irq_off", 1'b1, status_o.irq_off)
		`CHK("exc_mode_o", MODE_ABT, exc_mode_o)
		chk_reg(4'h0, 32'h1111_0000);
		chk_reg(4'h8, 32'h8888_0000);
		chk_reg(IDX_SP, 32'h0000_0000);
		chk_reg(IDX_LINK, 32'h0000_0100);
		chk_reg(IDX_PC, VEC_ABT + PC_AHEAD);
		exec(C_AL, '0, 3'h2, 5'h00, 32'h0);
		`CHK("status_o", STATUS_RESET, status_o)
		`CHK("pc_o", 32'h0000_0100, pc_o)
		chk_reg(IDX_SP, 32'hdddd_0000);
		chk_reg(IDX_LINK, 32'heeee_0000);
	endtask

	// Interrupts stay masked from reset, so they must remain pending
	task automatic t_priority();
		logic [4:0] modes[3];
		logic [31:0] vecs[3];
		modes = '{MODE_ABT, MODE_UND, MODE_SVC};
		vecs = '{VEC_ABT, VEC_UND, VEC_TRAP};
		exc(5'h1f, 32'h0000_0200);
		for (int i = 0; i < 3; i++) begin
			wait_taken();
			`CHK("exc_mode_o", modes[i], exc_mode_o)
			`CHK("pc_o", vecs[i], pc_o)
			@(posedge clk_i);
			#1;
		end
		`CHK("exc_pending_o", 5'h06, exc_pending_o)
		chk_reg(IDX_LINK, 32'h0000_0200);
		exec(C_AL, '0, 3'h1, 5'h00, 32'h0);
		`CHK("mode", MODE_UND, status_o.mode)
		`CHK("pc_o", 32'h0000_0200, pc_o)
	endtask

	task automatic t_cond();
		exec(C_AL, '0, 3'h0, 5'h14, 32'h0);
		`CHK("zero", 1'b1, status_o.zero)
		`CHK("neg", 1'b0, status_o.neg)
		exec(C_NE, w_of(4'h1, 32'h0000_0005), 3'h0, 5'h00, 32'h0);
		`CHK("cond_pass_o", 1'b0, cond_pass_o)
		chk_reg(4'h1, 32'h0000_0000);
		exec(C_EQ, w_of(4'h1, 32'h0000_0006), 3'h0, 5'h00, 32'h0);
		`CHK("cond_pass_o", 1'b1, cond_pass_o)
		chk_reg(4'h1, 32'h0000_0006);
		exec(C_NV, w_of(4'h1, 32'h0000_0007), 3'h0, 5'h00, 32'h0);
		`CHK("cond_pass_o", 1'b0, cond_pass_o)
		chk_reg(4'h1, 32'h0000_0006);
		exec(C_AL, '0, 3'h4, 5'h00, 32'h0000_0440);
		chk_reg(IDX_LINK, 32'h0000_0440);
	endtask

	// Unmask both interrupts, then walk system, fast and normal modes
	task automatic t_modes();
		status_word_t s;
		s = STATUS_RESET;
		s.irq_off = 1'b0;
		s.fast_off = 1'b0;
		s.mode = MODE_SYS;
		set_ctl(s);
		`CHK("status_o", s, status_o)
		exec(C_AL, w_of(4'h8, 32'h8000_0008), 3'h0, 5'h00, 32'h0);
		exec(C_AL, w_of(IDX_SP, 32'h5000_0013), 3'h0, 5'h00, 32'h0);
		exec(C_AL, '0, 3'h2, 5'h00, 32'h0000_0300);
		`CHK("mode", MODE_SYS, status_o.mode)
		`CHK("pc_o", 32'h0000_0300, pc_o)
		exc(5'h02, 32'h0000_0400);
		wait_taken();
		`CHK("pc_o", VEC_FAST, pc_o)
		`CHK("mode", MODE_FAST, status_o.mode)
		`CHK("fast_off", 1'b1, status_o.fast_off)
		chk_reg(4'h8, 32'h0000_0000);
		chk_reg(IDX_SP, 32'h0000_0000);
		chk_reg(IDX_LINK, 32'h0000_0400);
		exec(C_AL, w_of(4'h8, 32'hf8f8_0000), 3'h0, 5'h00, 32'h0);
		chk_reg(4'h8, 32'hf8f8_0000);
		exc(5'h04, 32'h0000_0500);
		`CHK("exc_pending_o", 5'h04, exc_pending_o)
		exec(C_AL, '0, 3'h2, 5'h00, 32'h0);
		`CHK("status_o", s, status_o)
		`CHK("pc_o", 32'h0000_0400, pc_o)
		wait_taken();
		`CHK("mode", MODE_IRQ, status_o.mode)
		`CHK("pc_o", VEC_IRQ, pc_o)
		chk_reg(4'h8, 32'h8000_0008);
		chk_reg(IDX_LINK, 32'h0000_0500);
		exec(C_AL, '0, 3'h1, 5'h00, 32'h0);
		`CHK("mode", MODE_SYS, status_o.mode)
		chk_reg(IDX_SP, 32'h5000_0013);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		rd_idx_a_i = 4'h0;
		rd_idx_b_i = 4'h0;
		instr_i = '0;
		wr_i = '0;
		flags_i = 4'h0;
		flags_we_i = 1'b0;
		exc_req_i = '0;
		exc_ret_addr_i = 32'h0;
		status_we_i = 1'b0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		#1;
		t_reset();
		t_banking();
		do_reset();
		t_priority();
		do_reset();
		t_cond();
		do_reset();
		t_modes();
		end_of_test();
	end
endmodule
